// *** core/rtc_consts.svh ***
// Function
// - Separate time counters, calendar rollover through 2099.
// - Alarm matches any enabled field combination.
// - Repeat mode re-triggers on every later match.
// - Alarm status bit polled, optionally drives interrupt.
// - Alarm interrupt pin open-drain, active low.
// - Interrupt holds until status cleared, or read with auto clear set.
// - Open-drain frequency output, host selected and enabled.
// - Low supply reset open-drain, low on brownout.
// - Brownout trip level has six choices.
// - Backup level flags at 85 and 75 percent.
// - Backup mode needs both supply comparisons true.
// - Serial bus ignored while on backup supply.
// - Brownout flag set, cleared by host read.
// - Repeat mode pulses interrupt 250ms, sets status.
// - Battery check only on request, not backup.
//
// Constants of the clock, alarm and supply monitor block.
// Assumes inclusion by bare name from files under core/.
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// ==========================================================
// Register offsets (word index on the register port)
`define ADDR_SEC        5'h00
`define ADDR_ALM_SEC    5'h07
`define ADDR_CTRL       5'h0D
`define ADDR_PWR        5'h0E
`define ADDR_STATUS     5'h0F
`define ADDR_IRQ_CLR    5'h10
`define ADDR_IRQ_EN     5'h11
`define TIME_FIELDS     7
`define ALM_FIELDS      6

// ==========================================================
// Field positions
`define ALM_FIELD_EN    7
`define CTRL_ALM_EN     0
`define CTRL_REPEAT     1
`define CTRL_AUTO_CLR   2
`define CTRL_MEASURE    3
`define CTRL_FSEL_LO    4
`define CTRL_FSEL_HI    7
`define PWR_SEL_HI      2
`define PWR_BAT85       4
`define PWR_BAT75       5
`define PWR_LOW_SUPPLY  6
`define STAT_ALARM      0
`define STAT_BROWNOUT   1
`define STAT_BATTERY    2
`define STAT_BACKUP     3

// ==========================================================
// Reset values and limits
`define RST_TIME        8'h00
`define RST_DAY         8'h01
`define RST_CTRL        8'h00
`define RST_BROWN_SEL   3'h0
`define BROWN_SEL_MAX   3'h5
`define SEC_MAX         8'h3B
`define HOUR_MAX        8'h17
`define MONTH_MAX       8'h0C
`define YEAR_MAX        8'h63
`define DOW_MAX         8'h06
`define PRESCALE_MAX    15'h7FFF

// ==========================================================
// Timing
`define CLK_MHZ         250
`define PULSE_MS        250
`define PULSE_CYCLES    (`PULSE_MS * `CLK_MHZ * 1000)

`endif

// *** core/rtc_pkg.sv ***
// Types shared by the clock, alarm and supply monitor block.
// Assumes the constants header sits beside it.
package rtc_pkg;

  // Register port request, one cycle per strobe
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_type;

  // Supply comparator inputs, all asynchronous to the clock
  typedef struct packed {
    logic       below_backup;
    logic       below_switch;
    logic [5:0] brownout_cmp;
    logic       bat_below_85;
    logic       bat_below_75;
  } supply_cmp_type;

  // Alarm interrupt pin state
  typedef enum logic [1:0] {
    LINE_IDLE,
    LINE_HOLD,
    LINE_PULSE
  } line_state_type;

endpackage

// *** core/sync2.sv ***
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes each bit is an independent level.
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First flop feeds only the second
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_r <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// *** core/field_counter.sv ***
// One wrapping time or calendar counter with load.
// Assumes inc and load are single-cycle strobes.
`timescale 1ns/1ps
module field_counter #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic       inc,
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  input  wire logic [7:0] min_val,
  input  wire logic [7:0] max_val,
  output logic      [7:0] value,
  output logic            carry
);

  // Carry to the next field on wrap
  assign carry = inc && (value >= max_val);

  // Count, wrap to minimum, or take a host write
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      value <= RST_VAL;
    end else if (ce) begin
      if (load) begin
        value <= load_val;
      end else if (carry) begin
        value <= min_val;
      end else if (inc) begin
        value <= value + 8'h01;
      end
    end
  end

endmodule

// *** core/rtc_alarm_power_status.sv ***
// Clock/calendar, alarm, frequency output and supply monitor.
// Assumes comparator levels and the oscillator arrive asynchronously.
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "rtc_consts.svh"
module rtc_alarm_power_status #(
  parameter int PULSE_CYCLES = `PULSE_CYCLES
) (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire logic                   ce,
  input  wire rtc_pkg::reg_req_type   reg_req,
  output logic [7:0]                  reg_rdata,
  input  wire logic                   osc_in,
  output logic                        osc_out,
  input  wire rtc_pkg::supply_cmp_type supply,
  output logic                        irq_n_o,
  output logic                        irq_n_oe,
  output logic                        freq_out_o,
  output logic                        freq_out_oe,
  output logic                        low_supply_reset_n_o,
  output logic                        low_supply_reset_n_oe,
  output logic                        backup_active,
  output logic                        irq
);
  import rtc_pkg::*;

  // ==========================================================
  // Synchronised inputs
  supply_cmp_type cmp_s;
  logic           osc_s;
  logic           osc_d_r;
  logic           osc_rise;

  // Comparator levels and oscillator through two flops
  sync2 #(.W(11)) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .ce      (ce),
    .d       ({supply, osc_in}),
    .q       ({cmp_s, osc_s})
  );

  // Edge of the timebase, crystal or direct drive alike
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      osc_d_r <= 1'b0;
      osc_out <= 1'b1;
    end else if (ce) begin
      osc_d_r <= osc_s;
      osc_out <= ~osc_s;
    end
  end
  assign osc_rise = osc_s && !osc_d_r;

  // ==========================================================
  // Supply mode and register port gating
  logic backup_r;
  logic wr_ok;
  logic rd_ok;
  logic backup_rise;

  // Backup only when both comparisons hold
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      backup_r      <= 1'b0;
      backup_active <= 1'b0;
    end else if (ce) begin
      backup_r      <= cmp_s.below_backup && cmp_s.below_switch;
      backup_active <= cmp_s.below_backup && cmp_s.below_switch;
    end
  end
  assign backup_rise = cmp_s.below_backup && cmp_s.below_switch && !backup_r;

  // Bus dead while on backup supply
  assign wr_ok = reg_req.wr && !backup_r;
  assign rd_ok = reg_req.rd && !backup_r;

  // ==========================================================
  // Prescaler and timekeeping
  logic [14:0] pre_r;
  logic        sec_tick;
  logic        tick_d_r;
  logic [7:0]  val   [`TIME_FIELDS];
  logic [7:0]  min_v [`TIME_FIELDS];
  logic [7:0]  max_v [`TIME_FIELDS];
  logic        inc_v [`TIME_FIELDS];
  logic        cry_v [`TIME_FIELDS];
  logic [7:0]  mdays;

  // Days in the current month, leap years every fourth
  always_comb begin
    unique case (val[4])
      8'h02: mdays = (val[5][1:0] == 2'h0) ? 8'h1D : 8'h1C;
      8'h04, 8'h06, 8'h09, 8'h0B: mdays = 8'h1E;
      default: mdays = 8'h1F;
    endcase
  end

  // Divide the timebase down to one tick per second
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pre_r    <= 15'h0000;
      tick_d_r <= 1'b0;
    end else if (ce) begin
      if (osc_rise) begin
        pre_r <= pre_r + 15'h0001;
      end
      tick_d_r <= sec_tick;
    end
  end
  assign sec_tick = osc_rise && (pre_r == `PRESCALE_MAX);

  // Limits and carry chain of the seven fields
  always_comb begin
    min_v[0] = 8'h00; max_v[0] = `SEC_MAX;   inc_v[0] = sec_tick;
    min_v[1] = 8'h00; max_v[1] = `SEC_MAX;   inc_v[1] = cry_v[0];
    min_v[2] = 8'h00; max_v[2] = `HOUR_MAX;  inc_v[2] = cry_v[1];
    min_v[3] = 8'h01; max_v[3] = mdays;      inc_v[3] = cry_v[2];
    min_v[4] = 8'h01; max_v[4] = `MONTH_MAX; inc_v[4] = cry_v[3];
    min_v[5] = 8'h00; max_v[5] = `YEAR_MAX;  inc_v[5] = cry_v[4];
    min_v[6] = 8'h00; max_v[6] = `DOW_MAX;   inc_v[6] = cry_v[2];
  end

  // One counter per field
  for (genvar i = 0; i < `TIME_FIELDS; i++) begin : g_field
    field_counter #(
      .RST_VAL ((i == 3 || i == 4) ? `RST_DAY : `RST_TIME)
    ) u_field (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .ce       (ce),
      .inc      (inc_v[i]),
      .load     (wr_ok && (reg_req.addr == 5'(`ADDR_SEC + i))),
      .load_val (reg_req.wdata),
      .min_val  (min_v[i]),
      .max_val  (max_v[i]),
      .value    (val[i]),
      .carry    (cry_v[i])
    );
  end

  // ==========================================================
  // Configuration registers
  logic [7:0] alm_r [`ALM_FIELDS];
  logic [7:0] ctrl_r;
  logic [2:0] brown_sel_r;
  logic [3:0] irq_en_r;
  logic [3:0] fsel;
  logic       meas_req;

  // Host writes to alarm, control, power and enable registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < `ALM_FIELDS; i++) begin
        alm_r[i] <= 8'h00;
      end
      ctrl_r      <= `RST_CTRL;
      brown_sel_r <= `RST_BROWN_SEL;
      irq_en_r    <= 4'h0;
    end else if (ce && wr_ok) begin
      for (int i = 0; i < `ALM_FIELDS; i++) begin
        if (reg_req.addr == 5'(`ADDR_ALM_SEC + i)) begin
          alm_r[i] <= reg_req.wdata;
        end
      end
      if (reg_req.addr == `ADDR_CTRL) begin
        ctrl_r <= reg_req.wdata & 8'hF7; // Measure bit is a strobe
      end
      if (reg_req.addr == `ADDR_PWR) begin
        // Six trip levels, codes above clamp to the last
        if (reg_req.wdata[`PWR_SEL_HI:0] > `BROWN_SEL_MAX) begin
          brown_sel_r <= `BROWN_SEL_MAX;
        end else begin
          brown_sel_r <= reg_req.wdata[`PWR_SEL_HI:0];
        end
      end
      if (reg_req.addr == `ADDR_IRQ_EN) begin
        irq_en_r <= reg_req.wdata[3:0];
      end
    end
  end
  assign fsel     = ctrl_r[`CTRL_FSEL_HI:`CTRL_FSEL_LO];
  assign meas_req = wr_ok && (reg_req.addr == `ADDR_CTRL) && reg_req.wdata[`CTRL_MEASURE];

  // ==========================================================
  // Alarm match
  logic alm_hit;
  logic alm_any;
  logic alarm_ev;

  // Every enabled field must equal the present time
  always_comb begin
    alm_hit = 1'b1;
    alm_any = 1'b0;
    for (int i = 0; i < `ALM_FIELDS; i++) begin
      if (alm_r[i][`ALM_FIELD_EN]) begin
        alm_any = 1'b1;
        if (alm_r[i][6:0] != val[(i == 5) ? 6 : i][6:0]) begin
          alm_hit = 1'b0;
        end
      end
    end
  end

  // Checked once after each seconds update; frequency output disables it
  assign alarm_ev = tick_d_r && ctrl_r[`CTRL_ALM_EN] && (fsel == 4'h0)
                    && alm_any && alm_hit;

  // ==========================================================
  // Brownout and battery level
  logic brown_lvl;
  logic brown_d_r;
  logic brown_rise;
  logic bat85_r;
  logic bat75_r;
  logic bat_ev;

  assign brown_lvl  = cmp_s.brownout_cmp[brown_sel_r];
  assign brown_rise = brown_lvl && !brown_d_r;
  assign bat_ev     = meas_req && cmp_s.bat_below_85;

  // Battery flags refresh only on a measurement request
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      brown_d_r <= 1'b0;
      bat85_r   <= 1'b0;
      bat75_r   <= 1'b0;
    end else if (ce) begin
      brown_d_r <= brown_lvl;
      if (meas_req) begin
        bat85_r <= cmp_s.bat_below_85;
        bat75_r <= cmp_s.bat_below_75;
      end
    end
  end

  // ==========================================================
  // Sticky status with enable, clear and read side effects
  logic [3:0] stat_r;
  logic [3:0] stat_set;
  logic [3:0] stat_clr;
  logic [3:0] stat_nxt;
  logic       stat_rd;

  assign stat_rd  = rd_ok && (reg_req.addr == `ADDR_STATUS);
  assign stat_set = {backup_rise, bat_ev, brown_rise, alarm_ev};

  // Clear register, auto clear of alarm and read clear of brownout
  always_comb begin
    stat_clr = 4'h0;
    if (wr_ok && (reg_req.addr == `ADDR_IRQ_CLR)) begin
      stat_clr = reg_req.wdata[3:0];
    end
    if (stat_rd) begin
      stat_clr[`STAT_BROWNOUT] = 1'b1;
      if (ctrl_r[`CTRL_AUTO_CLR]) begin
        stat_clr[`STAT_ALARM] = 1'b1;
      end
    end
    stat_nxt = (stat_r & ~stat_clr) | stat_set; // Set wins over clear
  end

  // Status and level interrupt
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stat_r <= 4'h0;
      irq    <= 1'b0;
    end else if (ce) begin
      stat_r <= stat_nxt;
      irq    <= |(stat_nxt & irq_en_r);
    end
  end

  // ==========================================================
  // Alarm interrupt pin
  line_state_type line_r;
  line_state_type line_nxt;
  logic [31:0]    pulse_cnt_r;

  // Hold until status clears, or pulse in repeat mode
  always_comb begin
    line_nxt = line_r;
    unique case (line_r)
      LINE_IDLE: begin
        if (alarm_ev) begin
          line_nxt = ctrl_r[`CTRL_REPEAT] ? LINE_PULSE : LINE_HOLD;
        end
      end
      LINE_HOLD: begin
        if (!stat_r[`STAT_ALARM]) begin
          line_nxt = LINE_IDLE;
        end
      end
      LINE_PULSE: begin
        if (alarm_ev) begin
          line_nxt = LINE_PULSE;
        end else if (pulse_cnt_r == 32'h0) begin
          line_nxt = LINE_IDLE;
        end
      end
    endcase
  end

  // Pulse timer, restarted by each match
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pulse_cnt_r <= 32'h0;
    end else if (ce) begin
      if (alarm_ev && ctrl_r[`CTRL_REPEAT]) begin
        pulse_cnt_r <= 32'(PULSE_CYCLES - 1);
      end else if ((line_r == LINE_PULSE) && (pulse_cnt_r != 32'h0)) begin
        pulse_cnt_r <= pulse_cnt_r - 32'h1;
      end
    end
  end

  // Open-drain pin driven low while active
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      line_r   <= LINE_IDLE;
      irq_n_o  <= 1'b0;
      irq_n_oe <= 1'b0;
    end else if (ce) begin
      line_r   <= line_nxt;
      irq_n_o  <= 1'b0;
      irq_n_oe <= (line_nxt != LINE_IDLE);
    end
  end

  // ==========================================================
  // Frequency and low supply outputs
  logic freq_lvl;

  assign freq_lvl = (fsel == 4'h0) ? 1'b1 : pre_r[4'(fsel - 4'h1)];

  // Open-drain pins pull low only, released otherwise
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      freq_out_o            <= 1'b0;
      freq_out_oe           <= 1'b0;
      low_supply_reset_n_o  <= 1'b0;
      low_supply_reset_n_oe <= 1'b0;
    end else if (ce) begin
      freq_out_o            <= 1'b0;
      freq_out_oe           <= !freq_lvl;
      low_supply_reset_n_o  <= 1'b0;
      low_supply_reset_n_oe <= brown_lvl;
    end
  end

  // ==========================================================
  // Read data, one cycle after the strobe
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    if (reg_req.addr < 5'(`ADDR_SEC + `TIME_FIELDS)) begin
      rd_mux = val[3'(reg_req.addr)];
    end else if (reg_req.addr < `ADDR_CTRL) begin
      rd_mux = alm_r[3'(reg_req.addr - `ADDR_ALM_SEC)];
    end else if (reg_req.addr == `ADDR_CTRL) begin
      rd_mux = ctrl_r;
    end else if (reg_req.addr == `ADDR_PWR) begin
      rd_mux = {1'b0, brown_lvl, bat75_r, bat85_r, 1'b0, brown_sel_r};
    end else if (reg_req.addr == `ADDR_STATUS) begin
      rd_mux = {4'h0, stat_r};
    end else if (reg_req.addr == `ADDR_IRQ_EN) begin
      rd_mux = {4'h0, irq_en_r};
    end
  end

  // Zero outside a read and during backup
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= rd_ok ? rd_mux : 8'h00;
    end
  end

endmodule

// *** test/rtc_alarm_power_status_props.sv ***
// Port checker for the clock, alarm and supply block.
// Assumes ce stays high and the bench holds inputs steady in reset.
`timescale 1ns/1ps
module rtc_alarm_power_status_props #(
  parameter int PULSE_CYCLES = 20
) (
  input wire logic                    clock,
  input wire logic                    sys_rst,
  input wire logic                    ce,
  input wire rtc_pkg::reg_req_type    reg_req,
  input wire logic [7:0]              reg_rdata,
  input wire logic                    osc_in,
  input wire logic                    osc_out,
  input wire rtc_pkg::supply_cmp_type supply,
  input wire logic                    irq_n_o,
  input wire logic                    irq_n_oe,
  input wire logic                    freq_out_o,
  input wire logic                    freq_out_oe,
  input wire logic                    low_supply_reset_n_o,
  input wire logic                    low_supply_reset_n_oe,
  input wire logic                    backup_active,
  input wire logic                    irq
);
  import rtc_pkg::*;
  // ==========================================
  // Pins, supply decision and register port
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  a_irq_pin_low: assert property (irq_n_o == 1'h0)
    else $error("alarm pin drives a high level");
  a_freq_pin_low: assert property (freq_out_o == 1'h0)
    else $error("frequency pin drives a high level");
  a_reset_pin_low: assert property (low_supply_reset_n_o == 1'h0)
    else $error("low supply pin drives a high level");
  a_reset_pin_on: assert property (
    (supply.brownout_cmp == 6'h3F) [*4] |-> low_supply_reset_n_oe)
    else $error("low supply pin idle under full brownout");
  a_reset_pin_off: assert property (
    (supply.brownout_cmp == 6'h00) [*4] |-> !low_supply_reset_n_oe)
    else $error("low supply pin active with no brownout");
  a_backup_entry: assert property (
    (supply.below_backup && supply.below_switch) [*5] |-> backup_active)
    else $error("backup mode not entered");
  a_backup_stay_off: assert property (
    !(supply.below_backup && supply.below_switch) [*5] |-> !backup_active)
    else $error("backup mode without both conditions");
  a_bus_silent: assert property (
    backup_active && reg_req.rd |=> reg_rdata == 8'h00)
    else $error("read answered in backup mode");
  a_rdata_one_cycle: assert property (
    !reg_req.rd |=> reg_rdata == 8'h00)
    else $error("read data outside the answer cycle");
  a_amp_inverts: assert property (
    $stable(osc_in) [*4] |-> osc_out == !osc_in)
    else $error("amplifier output not the inverse of its input");
endmodule

bind rtc_alarm_power_status rtc_alarm_power_status_props #(.PULSE_CYCLES(PULSE_CYCLES)) i_props (
  .clock(clock), .sys_rst(sys_rst), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .osc_in(osc_in), .osc_out(osc_out), .supply(supply), .irq_n_o(irq_n_o),
  .irq_n_oe(irq_n_oe), .freq_out_o(freq_out_o), .freq_out_oe(freq_out_oe),
  .low_supply_reset_n_o(low_supply_reset_n_o), .irq(irq),
  .low_supply_reset_n_oe(low_supply_reset_n_oe), .backup_active(backup_active)
);

// *** test/host_bus_model.sv ***
// Host processor model on the register port: single-byte accesses.
// Assumes the block clock and that the host never needs to wait.
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic           clock,
  output rtc_pkg::reg_req_type req,
  input  wire logic [7:0]     rdata
);
  import rtc_pkg::*;
  // ==========================================
  // Bus cycles
  initial req = '0;
  // One strobe cycle, then idle
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge clock);
    req.wr <= 1'h0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
    @(posedge clock);
    req.rd <= 1'h0;
    @(posedge clock);
    d = rdata;
  endtask
endmodule

// *** test/tb_rtc_alarm_power_status.sv ***
// Self-checking bench for the clock, alarm and supply block.
// Assumes the host model and the checker are compiled first.
`timescale 1ns/1ps
`include "rtc_consts.svh"
module tb_rtc_alarm_power_status;
  import rtc_pkg::*;
  logic           clock;
  logic           sys_rst;
  logic           osc_in = 1'h0;
  logic           osc_run;
  reg_req_type    reg_req;
  supply_cmp_type supply;
  logic [7:0]     reg_rdata;
  logic           osc_out;
  logic           irq_n_oe;
  logic           low_supply_reset_n_oe;
  logic           backup_active;
  logic           irq;
  logic           freq_out_oe;
  logic           f0;
  int             failures = 0;
  int             cmp_count = 0;
  logic [7:0]     tr[7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
  logic [7:0]     tv[7] = '{8'h3B, 8'h3B, 8'h17, 8'h1F, 8'h0C, 8'h63, 8'h06};

  // ==========================================
  // Block, host and clocks
  rtc_alarm_power_status #(.PULSE_CYCLES(20)) i_rtc_alarm_power_status (
    .clock(clock), .sys_rst(sys_rst), .ce(1'h1), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .osc_in(osc_in), .osc_out(osc_out), .supply(supply),
    .irq_n_o(), .irq_n_oe(irq_n_oe), .freq_out_o(), .freq_out_oe(freq_out_oe),
    .low_supply_reset_n_o(), .low_supply_reset_n_oe(low_supply_reset_n_oe),
    .backup_active(backup_active), .irq(irq)
  );
  host_bus_model i_host_bus (.clock(clock), .req(reg_req), .rdata(reg_rdata));
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  // Fast timebase, only while a second must pass or the frequency output is checked
  always @(posedge clock) if (osc_run) osc_in <= ~osc_in;

  // ==========================================
  // Helpers
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rchk(input string nm, input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host_bus.rd(a, d);
    chk(nm, d, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge clock);
    failures++;
    complete_run;
  end

  // ==========================================
  // Test sequence
  initial begin
    sys_rst = 1'h1;
    osc_run = 1'h0;
    supply = '0;
    repeat (12) @(posedge clock);
    sys_rst <= 1'h0;
    for (int i = 0; i < 7; i++) rchk("time_rst", i[4:0], tr[i]);
    // Trip level select clamps at the sixth choice
    for (int i = 0; i < 8; i++) begin
      i_host_bus.wr(`ADDR_PWR, 8'(i));
      rchk("pwr_sel", `ADDR_PWR, (i > 5) ? 8'h05 : 8'(i));
    end
    // Brownout on level 2 only
    i_host_bus.wr(`ADDR_PWR, 8'h02);
    supply.brownout_cmp <= 6'h02;
    cyc(5);
    chk("lvr_other", low_supply_reset_n_oe, 8'h00);
    supply.brownout_cmp <= 6'h04;
    cyc(5);
    chk("lvr_on", low_supply_reset_n_oe, 8'h01);
    rchk("pwr_live", `ADDR_PWR, 8'h42);
    rchk("brown_set", `ADDR_STATUS, 8'h02);
    rchk("brown_rd_clr", `ADDR_STATUS, 8'h00);
    // Second brownout: masked, enabled, cleared
    supply.brownout_cmp <= 6'h00;
    cyc(5);
    supply.brownout_cmp <= 6'h3F;
    cyc(5);
    chk("irq_masked", irq, 8'h00);
    i_host_bus.wr(`ADDR_IRQ_EN, 8'h02);
    cyc(2);
    chk("irq_enabled", irq, 8'h01);
    i_host_bus.wr(`ADDR_IRQ_CLR, 8'h02);
    cyc(2);
    chk("irq_cleared", irq, 8'h00);
    supply.brownout_cmp <= 6'h00;
    cyc(5);
    chk("lvr_off", low_supply_reset_n_oe, 8'h00);
    // Battery flags move only on a measure request
    supply.bat_below_85 <= 1'h1;
    cyc(5);
    rchk("bat_no_meas", `ADDR_PWR, 8'h02);
    i_host_bus.wr(`ADDR_CTRL, 8'h08);
    rchk("bat_85", `ADDR_PWR, 8'h12);
    rchk("bat_status", `ADDR_STATUS, 8'h04);
    rchk("ctrl_meas", `ADDR_CTRL, 8'h00);
    supply.bat_below_75 <= 1'h1;
    cyc(5);
    i_host_bus.wr(`ADDR_CTRL, 8'h08);
    rchk("bat_75", `ADDR_PWR, 8'h32);
    i_host_bus.wr(`ADDR_IRQ_CLR, 8'h0F);
    // Alarm at second and minute zero across a full calendar rollover
    i_host_bus.wr(`ADDR_IRQ_EN, 8'h01);
    for (int i = 0; i < 7; i++) i_host_bus.wr(`ADDR_SEC + i[4:0], tv[i]);
    i_host_bus.wr(`ADDR_ALM_SEC, 8'h80);
    i_host_bus.wr(`ADDR_ALM_SEC + 5'h01, 8'h80);
    i_host_bus.wr(`ADDR_CTRL, 8'h01);
    chk("irq_before", irq_n_oe, 8'h00);
    osc_run <= 1'h1;
    for (int i = 0; i < 70000 && irq_n_oe !== 1'h1; i++) @(posedge clock);
    osc_run <= 1'h0;
    chk("irq_pin", irq_n_oe, 8'h01);
    chk("irq_line", irq, 8'h01);
    for (int i = 0; i < 7; i++) rchk("time_roll", i[4:0], tr[i]);
    rchk("alarm_status", `ADDR_STATUS, 8'h01);
    chk("irq_hold", irq_n_oe, 8'h01);
    // Auto clear: the status read itself releases the pin
    i_host_bus.wr(`ADDR_CTRL, 8'h05);
    rchk("alarm_auto_rd", `ADDR_STATUS, 8'h01);
    rchk("alarm_auto_clr", `ADDR_STATUS, 8'h00);
    cyc(3);
    chk("irq_release", irq_n_oe, 8'h00);
    chk("irq_low", irq, 8'h00);
    // Frequency output follows prescaler bit 0, off when deselected
    i_host_bus.wr(`ADDR_CTRL, 8'h10);
    osc_run <= 1'h1;
    cyc(8);
    f0 = freq_out_oe;
    cyc(2);
    chk("freq_toggle", f0 ^ freq_out_oe, 8'h01);
    osc_run <= 1'h0;
    i_host_bus.wr(`ADDR_CTRL, 8'h00);
    cyc(4);
    chk("freq_off", freq_out_oe, 8'h00);
    // Backup mode needs both conditions and silences the bus
    supply.below_switch <= 1'h1;
    cyc(6);
    chk("backup_one", backup_active, 8'h00);
    supply.below_backup <= 1'h1;
    cyc(6);
    chk("backup_both", backup_active, 8'h01);
    i_host_bus.wr(`ADDR_ALM_SEC, 8'h55);
    rchk("bus_off", `ADDR_ALM_SEC, 8'h00);
    supply.below_switch <= 1'h0;
    cyc(6);
    rchk("wr_refused", `ADDR_ALM_SEC, 8'h80);
    rchk("status_backup", `ADDR_STATUS, 8'h08);
    i_host_bus.wr(`ADDR_IRQ_CLR, 8'h08);
    rchk("status_cleared", `ADDR_STATUS, 8'h00);
    complete_run;
  end
endmodule
